/* src/sbc_cpu.sv */
// Processor end of the system bus sideband control
module sbc_cpu
  import sbc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  sbc_if.dev                    link,
  input  wire logic             lic_cfg_wr,
  input  wire logic             lic_cfg_enable,
  input  wire logic             req_valid,
  input  wire logic [REQ_W-1:0] req_cmd,
  input  wire logic             req_locked,
  input  wire logic             req_last,
  input  wire logic             temp_max,
  input  wire logic             throttle_enable,
  input  wire logic             internal_error,
  input  wire logic             mc_enable,
  input  wire logic             mc_internal_fault_flag_enable,
  input  wire logic             mc_initiator_enable,
  input  wire logic             initiator_error,
  input  wire logic             observed_error,
  output logic                  req_ready,
  output logic [1:0]            lint_irq,
  output logic                  maskable_irq_request,
  output logic                  nmi_request,
  output logic                  throttle_active,
  output logic                  fault_q,
  output logic                  cache_invalidate,
  output logic [REQ_W-1:0]      config_q,
  output logic                  builtin_self_test_start,
  output logic                  req_seen,
  output logic [REQ_W-1:0]      req_seen_cmd
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int SW = REQ_W + 8;

  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic          bclk_s;
  logic          reset_s;
  logic          pwr_s;
  logic [1:0]    lint_s;
  logic          init_s;
  logic          therm_s;
  logic          strobe_s;
  logic [REQ_W-1:0] req_s;

  // Every pin input crosses two stages; only stage two is read
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {link.bus_clk, link.sys_reset, link.power_stable_input,
                  link.local_interrupt_pins, link.soft_init, link.therm_w,
                  link.strobe_w, link.req_w};
      sync2_q <= sync1_q;
    end
  end

  assign {bclk_s, reset_s, pwr_s, lint_s, init_s, therm_s, strobe_s, req_s} =
    sync2_q;

  // ----------------------------------------------------------------
  // Bus clock edges and effective reset
  // ----------------------------------------------------------------
  logic bclk_d1_q;
  logic strobe_d1_q;
  logic in_reset_q;
  logic bus_rise;
  logic held;

  assign bus_rise = bclk_s & ~bclk_d1_q;
  // Power not stable acts like reset: nothing trusts the bus then
  assign held     = reset_s | ~pwr_s;

  // Edge history and reset state
  always_ff @(posedge clk) begin
    if (rst) begin
      bclk_d1_q   <= 1'b0;
      strobe_d1_q <= 1'b0;
      in_reset_q  <= 1'b1;
    end else begin
      bclk_d1_q   <= bclk_s;
      strobe_d1_q <= strobe_s;
      in_reset_q  <= held;
    end
  end

  // Cache drop on entry to reset, no writeback path exists
  always_ff @(posedge clk) begin
    if (rst) begin
      cache_invalidate <= 1'b0;
    end else begin
      cache_invalidate <= held & ~in_reset_q;
    end
  end

  // Configuration and self-test request caught on release
  always_ff @(posedge clk) begin
    if (rst) begin
      config_q   <= '0;
      builtin_self_test_start <= 1'b0;
    end else begin
      builtin_self_test_start <= 1'b0;
      if (in_reset_q && !held) begin
        config_q   <= req_s;
        builtin_self_test_start <= init_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // Local interrupt pins
  // ----------------------------------------------------------------
  logic lic_en_q;

  // Controller enabled after every reset until software turns it off
  always_ff @(posedge clk) begin
    if (rst || held) begin
      lic_en_q <= 1'b1;
    end else if (lic_cfg_wr) begin
      lic_en_q <= lic_cfg_enable;
    end
  end

  // Pins are asynchronous, already synchronised above
  always_ff @(posedge clk) begin
    if (rst || held) begin
      lint_irq             <= 2'h0;
      maskable_irq_request <= 1'b0;
      nmi_request          <= 1'b0;
    end else begin
      lint_irq             <= lic_en_q ? lint_s : 2'h0;
      maskable_irq_request <= ~lic_en_q & lint_s[0];
      nmi_request          <= ~lic_en_q & lint_s[1];
    end
  end

  // ----------------------------------------------------------------
  // Request phase and lock sequencing
  // ----------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_DRIVE} sbc_req_e;

  sbc_req_e         state_q;
  logic [REQ_W-1:0] cmd_q;
  logic             last_q;
  logic             lock_q;

  // One transaction per two bus clocks: one bus clock driving, one idle; owner drives command and strobe
  always_ff @(posedge clk) begin
    if (rst || held) begin
      state_q <= ST_IDLE;
      cmd_q   <= '0;
      last_q  <= 1'b0;
      lock_q  <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (bus_rise && req_valid) begin
            state_q <= ST_DRIVE;
            cmd_q   <= req_cmd;
            last_q  <= req_last;
            if (req_locked) begin
              lock_q <= 1'b1;
            end
          end
        end
        ST_DRIVE: begin
          if (bus_rise) begin
            state_q <= ST_IDLE;
            // Lock drops only after the last transaction of the sequence
            if (last_q) begin
              lock_q <= 1'b0;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Ready only in idle; a request is taken at the next bus edge
  always_ff @(posedge clk) begin
    if (rst || held) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (state_q == ST_IDLE) & ~(bus_rise & req_valid);
    end
  end

  // Commands seen on the bus, sampled on strobe rise
  always_ff @(posedge clk) begin
    if (rst || held) begin
      req_seen     <= 1'b0;
      req_seen_cmd <= '0;
    end else begin
      req_seen <= strobe_s & ~strobe_d1_q;
      if (strobe_s && !strobe_d1_q) begin
        req_seen_cmd <= req_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // Internal fault and machine check
  // ----------------------------------------------------------------
  logic mc_evt_q;

  // Sticky until reset
  always_ff @(posedge clk) begin
    if (rst || reset_s) begin
      fault_q <= 1'b0;
    end else if (internal_error) begin
      fault_q <= 1'b1;
    end
  end

  // Transaction errors stretched to the next bus edge; set beats clear
  always_ff @(posedge clk) begin
    if (rst || held) begin
      mc_evt_q <= 1'b0;
    end else if (observed_error || (mc_initiator_enable && initiator_error)) begin
      mc_evt_q <= 1'b1;
    end else if (bus_rise) begin
      mc_evt_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Thermal alarm and throttle
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || held) begin
      throttle_active <= 1'b0;
    end else begin
      // System alarm keeps throttle on until the pin is released
      throttle_active <= throttle_enable & (temp_max | therm_s);
    end
  end

  // ----------------------------------------------------------------
  // Link outputs, all released while reset is observed
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || held) begin
      link.dev_lock_oe         <= 1'b0;
      link.dev_mchk_oe         <= 1'b0;
      link.dev_therm_oe        <= 1'b0;
      link.internal_fault_flag <= 1'b0;
      link.dev_req_o           <= '0;
      link.dev_req_oe          <= 1'b0;
      link.dev_strobe_oe       <= 1'b0;
    end else begin
      link.dev_lock_oe         <= lock_q;
      // Observed errors, initiator errors when mc_initiator_enable is set, and the internal fault when its enable is set reach this pin, all gated by mc_enable
      link.dev_mchk_oe         <= mc_enable & (mc_evt_q | (mc_internal_fault_flag_enable & fault_q));
      link.dev_therm_oe        <= temp_max;
      link.internal_fault_flag <= fault_q;
      link.dev_req_o           <= (state_q == ST_DRIVE) ? cmd_q : '0;
      link.dev_req_oe          <= (state_q == ST_DRIVE);
      link.dev_strobe_oe       <= (state_q == ST_DRIVE);
    end
  end

endmodule : sbc_cpu

/* common/sbc_pkg.sv */
// Shared constants of the system bus sideband control block
package sbc_pkg;

  // ----------------------------------------------------------------
  // Clocking and link timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 4;
  localparam int BUS_CLK_PERIOD_NS = 160;
  localparam int BUS_HALF_CYC      = BUS_CLK_PERIOD_NS / CLK_PERIOD_NS / 2;
  localparam int REQ_W             = 5;
  localparam int SYNC_STAGES       = 2;

  // ----------------------------------------------------------------
  // Reset timing held by the chipset end
  // ----------------------------------------------------------------
  localparam int RESET_MIN_US  = 1000;
  localparam int RESET_MAX_US  = 10000;
  localparam int RESET_MIN_CYC = (RESET_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_MAX_CYC = (RESET_MAX_US * 1000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Chipset register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_CTRL     = 5'h00;
  localparam logic [4:0] OFF_CMD      = 5'h04;
  localparam logic [4:0] OFF_STATUS   = 5'h08;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h0C;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h10;

  // Control register fields
  localparam int CTRL_PWR     = 0;
  localparam int CTRL_RST     = 1;
  localparam int CTRL_INIT    = 2;
  localparam int CTRL_LINT0   = 3;
  localparam int CTRL_LINT1   = 4;
  localparam int CTRL_PRIO    = 5;
  localparam int CTRL_THERM   = 6;
  localparam int CTRL_MCHK    = 7;
  localparam int CTRL_W       = 8;
  localparam logic [7:0] CTRL_RESET = 8'h02;

  // Command register fields
  localparam int CMD_GO       = 8;

  // Status register fields
  localparam int ST_LOCK      = 0;
  localparam int ST_MCHK      = 1;
  localparam int ST_THERM     = 2;
  localparam int ST_FAULT     = 3;
  localparam int ST_BUSY      = 4;
  localparam int ST_RESET     = 5;
  localparam int ST_REQ_LSB   = 8;

  // Interrupt status fields
  localparam int IRQ_REQ      = 0;
  localparam int IRQ_MCHK     = 1;
  localparam int IRQ_THERM    = 2;
  localparam int IRQ_FAULT    = 3;
  localparam int IRQ_W        = 4;

endpackage : sbc_pkg

/* common/sbc_if.sv */
// Link between the processor end and the chipset end of the sideband
interface sbc_if;
  import sbc_pkg::*;

  // ----------------------------------------------------------------
  // Driven by the chipset
  // ----------------------------------------------------------------
  logic             bus_clk;
  logic             sys_reset;
  logic             power_stable_input;
  logic [1:0]       local_interrupt_pins;
  logic             soft_init;
  logic             priority_bus_request;
  logic             host_mchk_oe;
  logic             host_therm_oe;
  logic [REQ_W-1:0] host_req_o;
  logic             host_req_oe;
  logic             host_strobe_oe;

  // ----------------------------------------------------------------
  // Driven by the processor
  // ----------------------------------------------------------------
  logic             dev_lock_oe;
  logic             dev_mchk_oe;
  logic             dev_therm_oe;
  logic             internal_fault_flag;
  logic [REQ_W-1:0] dev_req_o;
  logic             dev_req_oe;
  logic             dev_strobe_oe;

  // ----------------------------------------------------------------
  // Resolved wired levels, asserted high
  // ----------------------------------------------------------------
  logic             lock_w;
  logic             mchk_w;
  logic             therm_w;
  logic [REQ_W-1:0] req_w;
  logic             strobe_w;

  assign lock_w   = dev_lock_oe;
  assign mchk_w   = dev_mchk_oe | host_mchk_oe;
  assign therm_w  = dev_therm_oe | host_therm_oe;
  assign req_w    = (dev_req_oe ? dev_req_o : '0) | (host_req_oe ? host_req_o : '0);
  assign strobe_w = dev_strobe_oe | host_strobe_oe;

  modport dev (
    input  bus_clk, sys_reset, power_stable_input, local_interrupt_pins, soft_init,
    input  priority_bus_request, lock_w, mchk_w, therm_w, req_w, strobe_w,
    output dev_lock_oe, dev_mchk_oe, dev_therm_oe, internal_fault_flag,
    output dev_req_o, dev_req_oe, dev_strobe_oe
  );

  modport host (
    output bus_clk, sys_reset, power_stable_input, local_interrupt_pins, soft_init,
    output priority_bus_request, host_mchk_oe, host_therm_oe,
    output host_req_o, host_req_oe, host_strobe_oe,
    input  lock_w, mchk_w, therm_w, req_w, strobe_w, internal_fault_flag
  );

endinterface : sbc_if

/* src/sbc_chipset.sv */
// Chipset end of the system bus sideband control, Avalon-MM controlled
module sbc_chipset
  import sbc_pkg::*;
#(
  parameter int RESET_MIN = RESET_MIN_CYC,
  parameter int RESET_MAX = RESET_MAX_CYC
)(
  input  wire logic        clk,
  input  wire logic        rst,
  sbc_if.host              link,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Synchronisers for processor-driven levels
  // ----------------------------------------------------------------
  localparam int SW = REQ_W + 5;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic lock_s, mchk_s, therm_s, fault_s, strobe_s;
  logic [REQ_W-1:0] req_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {link.lock_w, link.mchk_w, link.therm_w, link.internal_fault_flag,
                  link.strobe_w, link.req_w};
      sync2_q <= sync1_q;
    end
  end
  assign {lock_s, mchk_s, therm_s, fault_s, strobe_s, req_s} = sync2_q;

  // ----------------------------------------------------------------
  // Bus clock divider
  // ----------------------------------------------------------------
  logic [7:0] div_q;
  logic       bus_rise;
  assign bus_rise = (div_q == 8'(BUS_HALF_CYC - 1)) & ~link.bus_clk;

  always_ff @(posedge clk) begin
    if (rst) begin
      div_q        <= '0;
      link.bus_clk <= 1'b0;
    end else if (div_q == 8'(BUS_HALF_CYC - 1)) begin
      div_q        <= '0;
      link.bus_clk <= ~link.bus_clk;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Avalon slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_q;
  logic [REQ_W-1:0]  cmd_q;
  logic              go_q;
  logic              busy_q;
  logic [IRQ_W-1:0]  ist_q;
  logic [IRQ_W-1:0]  imask_q;
  logic [REQ_W-1:0]  seen_q;
  logic              wr_take;
  logic [IRQ_W-1:0]  ev;
  logic [3:0]        prev_q;

  assign wr_take = avs_write & ~avs_waitrequest;

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      if (avs_address == OFF_CTRL) begin
        avs_readdata <= 32'(ctrl_q);
      end else if (avs_address == OFF_CMD) begin
        avs_readdata <= 32'({go_q, 3'h0, cmd_q});
      end else if (avs_address == OFF_STATUS) begin
        avs_readdata <= 32'({seen_q, 2'h0, link.sys_reset, busy_q, fault_s, therm_s, mchk_s,
                             lock_s});
      end else if (avs_address == OFF_IRQ_STAT) begin
        avs_readdata <= 32'(ist_q);
      end else if (avs_address == OFF_IRQ_MASK) begin
        avs_readdata <= 32'(imask_q);
      end else begin
        avs_readdata <= '0;
      end
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Control and mask registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q  <= CTRL_RESET;
      imask_q <= '0;
    end else if (wr_take && avs_address == OFF_CTRL) begin
      ctrl_q <= avs_writedata[CTRL_W-1:0];
    end else if (wr_take && avs_address == OFF_IRQ_MASK) begin
      imask_q <= avs_writedata[IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Reset sequencing: at least the minimum, never past the maximum
  // ----------------------------------------------------------------
  logic [31:0] rcnt_q;
  logic        pwr_d1_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      rcnt_q         <= '0;
      pwr_d1_q       <= 1'b0;
      link.sys_reset <= 1'b1;
    end else begin
      pwr_d1_q <= ctrl_q[CTRL_PWR];
      if (!ctrl_q[CTRL_PWR] || (ctrl_q[CTRL_PWR] && !pwr_d1_q)) begin
        rcnt_q         <= '0;
        link.sys_reset <= 1'b1;
      end else if (link.sys_reset) begin
        rcnt_q <= rcnt_q + 32'h1;
        // Release after the minimum once software lets go, force at maximum
        if ((rcnt_q >= 32'(RESET_MIN - 1) && !ctrl_q[CTRL_RST]) ||
            rcnt_q >= 32'(RESET_MAX - 1)) begin
          link.sys_reset <= 1'b0;
        end
      end else if (ctrl_q[CTRL_RST]) begin
        rcnt_q         <= '0;
        link.sys_reset <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command issue behind the priority request
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || link.sys_reset) begin
      cmd_q  <= '0;
      go_q   <= 1'b0;
      busy_q <= 1'b0;
    end else if (wr_take && avs_address == OFF_CMD && !go_q) begin
      cmd_q <= avs_writedata[REQ_W-1:0];
      go_q  <= avs_writedata[CMD_GO];
    end else if (go_q && bus_rise && !busy_q && !lock_s) begin
      busy_q <= 1'b1;
    end else if (busy_q && bus_rise) begin
      busy_q <= 1'b0;
      go_q   <= 1'b0;
    end
  end

  // Pin drive, released at once while reset is asserted
  always_ff @(posedge clk) begin
    if (rst || link.sys_reset) begin
      link.priority_bus_request <= 1'b0;
      link.host_mchk_oe         <= 1'b0;
      link.host_therm_oe        <= 1'b0;
      link.host_req_o           <= '0;
      link.host_req_oe          <= 1'b0;
      link.host_strobe_oe       <= 1'b0;
    end else begin
      link.priority_bus_request <= ctrl_q[CTRL_PRIO] | go_q;
      link.host_mchk_oe         <= ctrl_q[CTRL_MCHK];
      link.host_therm_oe        <= ctrl_q[CTRL_THERM];
      link.host_req_o           <= busy_q ? cmd_q : '0;
      link.host_req_oe          <= busy_q;
      link.host_strobe_oe       <= busy_q;
    end
  end

  // Levels that stay valid through reset: power, init strap, interrupts
  always_ff @(posedge clk) begin
    if (rst) begin
      link.power_stable_input   <= 1'b0;
      link.soft_init            <= 1'b0;
      link.local_interrupt_pins <= 2'h0;
    end else begin
      link.power_stable_input   <= ctrl_q[CTRL_PWR];
      link.soft_init            <= ctrl_q[CTRL_INIT];
      link.local_interrupt_pins <= {ctrl_q[CTRL_LINT1], ctrl_q[CTRL_LINT0]};
    end
  end

  // ----------------------------------------------------------------
  // Events, sticky status, write-one-to-clear; set wins
  // ----------------------------------------------------------------
  assign ev = {fault_s & ~prev_q[3], therm_s & ~prev_q[2], mchk_s & ~prev_q[1],
               strobe_s & ~prev_q[0] & ~busy_q};

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= '0;
      seen_q <= '0;
      ist_q  <= '0;
      irq    <= 1'b0;
    end else begin
      prev_q <= {fault_s, therm_s, mchk_s, strobe_s};
      if (ev[IRQ_REQ]) begin
        seen_q <= req_s;
      end
      if (wr_take && avs_address == OFF_IRQ_STAT) begin
        ist_q <= (ist_q & ~avs_writedata[IRQ_W-1:0]) | ev;
      end else begin
        ist_q <= ist_q | ev;
      end
      irq <= |(ist_q & imask_q);
    end
  end

endmodule : sbc_chipset

/* verif/sbc_properties.sv */
// Concurrent checks on the sideband link between the two ends
module sbc_properties #(
  parameter int RESET_MIN = 20,
  parameter int RESET_MAX = 200
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic sys_reset,
  input wire logic power_stable_input,
  input wire logic priority_bus_request,
  input wire logic lock_w,
  input wire logic host_req_oe,
  input wire logic dev_lock_oe,
  input wire logic dev_req_oe,
  input wire logic dev_strobe_oe,
  input wire logic internal_fault_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // Link properties
  // ------------------------------------------------------------
  // Two bus clocks is 80 system clocks
  sequence s_dev_quiet;
    !(dev_lock_oe || dev_req_oe || dev_strobe_oe || internal_fault_flag);
  endsequence
  a_release_reset: assert property ($rose(sys_reset) |-> ##[1:80] s_dev_quiet)
    else $error("device outputs still driven after reset");
  a_strobe_req: assert property (dev_strobe_oe |-> dev_req_oe)
    else $error("strobe without command");
  a_strobe_hold: assert property ($rose(dev_strobe_oe) |-> dev_strobe_oe [*8])
    else $error("command strobe too short");
  a_lock_start: assert property ($rose(dev_lock_oe) |-> dev_req_oe)
    else $error("lock raised outside a transaction");
  a_lock_end: assert property ($fell(dev_lock_oe) |-> !dev_req_oe)
    else $error("lock dropped inside a transaction");
  a_prio_wait: assert property ($rose(host_req_oe) |-> !lock_w && $past(priority_bus_request))
    else $error("priority agent took the bus under lock");
  a_fault_sticky: assert property (internal_fault_flag && !sys_reset && power_stable_input
    |=> internal_fault_flag)
    else $error("internal fault flag dropped");
  a_reset_min: assert property ($fell(sys_reset) |-> $past(sys_reset, RESET_MIN))
    else $error("link reset too short");
  // Cycles of reset with power up; must end by the maximum
  int hold_cnt_q;
  always_ff @(posedge clk) begin
    if (rst || !sys_reset || !power_stable_input) begin
      hold_cnt_q <= 0;
    end else begin
      hold_cnt_q <= hold_cnt_q + 1;
    end
  end
  a_reset_max: assert property (hold_cnt_q <= RESET_MAX)
    else $error("link reset held too long");
endmodule : sbc_properties

/* verif/cpu_bus_sideband_control_tb.sv */
// Testbench joining the processor and chipset ends of the sideband
module cpu_bus_sideband_control_tb;
  import sbc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 0, rst = 1, wen = 0, ren = 0, cw = 0, ce = 0, rv = 0, rl = 0, rla = 0;
  logic        tm = 0, te = 0, ie = 0, me = 0, mie = 0, irq, rdy, thr, flt, mi, nmi, wrq;
  logic        xe = 0, oe = 0, mne = 0, ci, bs, rs, ci_q = 0, bs_q = 0, rs_q = 0;
  logic [4:0]  adr = 0, rc = 0, scmd, cfg;
  logic [31:0] wd = 0, rdd, q;
  logic [1:0]  li;
  int          err_total = 0, n_compared = 0;
  sbc_if lk();
  sbc_cpu sbc_cpu_inst (.clk(clk), .rst(rst), .link(lk.dev), .lic_cfg_wr(cw),
    .lic_cfg_enable(ce), .req_valid(rv), .req_cmd(rc), .req_locked(rl), .req_last(rla),
    .temp_max(tm), .throttle_enable(te), .internal_error(ie), .mc_enable(me),
    .mc_internal_fault_flag_enable(mie), .mc_initiator_enable(mne), .initiator_error(xe),
    .observed_error(oe), .req_ready(rdy), .lint_irq(li), .maskable_irq_request(mi),
    .nmi_request(nmi), .throttle_active(thr), .fault_q(flt), .cache_invalidate(ci),
    .config_q(cfg), .builtin_self_test_start(bs), .req_seen(rs), .req_seen_cmd(scmd));
  sbc_chipset #(.RESET_MIN(20), .RESET_MAX(200)) sbc_chipset_inst (.clk(clk), .rst(rst),
    .link(lk.host), .avs_address(adr), .avs_read(ren), .avs_write(wen), .avs_writedata(wd),
    .avs_readdata(rdd), .avs_waitrequest(wrq), .irq(irq));
  sbc_properties #(.RESET_MIN(20), .RESET_MAX(200)) sbc_properties_inst (.clk(clk), .rst(rst),
    .sys_reset(lk.sys_reset), .power_stable_input(lk.power_stable_input),
    .priority_bus_request(lk.priority_bus_request), .lock_w(lk.lock_w),
    .host_req_oe(lk.host_req_oe), .dev_lock_oe(lk.dev_lock_oe), .dev_req_oe(lk.dev_req_oe),
    .dev_strobe_oe(lk.dev_strobe_oe), .internal_fault_flag(lk.internal_fault_flag));
  always #2 clk = ~clk;
  // Pulses are caught here so that a later look cannot miss them
  always @(posedge clk) begin
    if (!rst) begin
      ci_q <= ci_q | ci;
      bs_q <= bs_q | bs;
      rs_q <= rs_q | rs;
    end
  end
  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask : cy
  // Request held until waitrequest is sampled low
  task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
    wen <= w;
    ren <= !w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    // Only the watchdog ends a wait that never sees an answer
    while (wrq !== 1'b0) @(posedge clk);
    q = rdd;
    wen <= 0;
    ren <= 0;
    cy(1);
  endtask : av
  task automatic ck(input string s, input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : ck
  // Wait on the idle flag; the watchdog bounds it
  task automatic wr(input logic v);
    while (rdy !== v) @(posedge clk);
  endtask : wr
  // Clear the machine check event, pulse an error source, read events
  task automatic mcp(input logic i, input logic o);
    av(1, OFF_IRQ_STAT, 32'h2);
    xe <= i;
    oe <= o;
    cy(1);
    xe <= 0;
    oe <= 0;
    cy(50);
    av(0, OFF_IRQ_STAT, 0);
  endtask : mcp
  task automatic finish_test();
    if (err_total == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  initial begin
    #100000;
    err_total++;
    finish_test();
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    cy(16);
    rst <= 0;
    cy(1);
    av(1, OFF_CTRL, 32'h19);
    cy(100);
    av(0, OFF_STATUS, 0);
    ck("link reset", q[ST_RESET], 0);
    ck("pins on", li, 2'h3);
    ck("no early pulse", {ci_q, bs_q, rs_q}, 3'h0);
    cw <= 1;
    cy(1);
    cw <= 0;
    cy(10);
    ck("pins off", {li, nmi, mi}, 4'h3);
    av(1, OFF_IRQ_STAT, 32'hF);
    av(1, OFF_IRQ_MASK, 32'h1);
    rc <= 5'h15;
    rl <= 1;
    rv <= 1;
    wr(0);
    rla <= 1;
    wr(1);
    ck("lock held", lk.lock_w, 1);
    wr(0);
    rv <= 0;
    wr(1);
    cy(3);
    av(0, OFF_STATUS, 0);
    ck("cmd seen", q[12:0] & 13'h1F01, 13'h1500);
    ck("irq set", irq, 1);
    av(1, OFF_IRQ_STAT, 32'h1);
    cy(2);
    ck("irq clr", irq, 0);
    av(1, OFF_CMD, 32'h10A);
    cy(100);
    ck("host cmd", {rs_q, scmd}, 6'h2A);
    te <= 1;
    tm <= 1;
    cy(10);
    ck("hot out", thr, 1);
    av(0, OFF_STATUS, 0);
    ck("hot status", q[ST_THERM], 1);
    tm <= 0;
    av(1, OFF_CTRL, 32'h59);
    cy(10);
    ck("hot in", thr, 1);
    av(1, OFF_CTRL, 32'h19);
    cy(10);
    ck("hot off", thr, 0);
    me <= 1;
    mcp(1, 0);
    ck("initiator off", q[IRQ_MCHK], 0);
    mne <= 1;
    mcp(1, 0);
    ck("initiator on", q[IRQ_MCHK], 1);
    mne <= 0;
    mcp(0, 1);
    ck("observed", q[IRQ_MCHK], 1);
    mie <= 1;
    ie <= 1;
    cy(1);
    ie <= 0;
    cy(50);
    av(0, OFF_STATUS, 0);
    ck("fault", {q[ST_FAULT], q[ST_MCHK], flt}, 3'h7);
    av(1, OFF_CTRL, 32'h1F);
    cy(100);
    ck("reset state", flt, 0);
    cy(150);
    av(1, OFF_CTRL, 32'h1D);
    cy(20);
    ck("pins default", li, 2'h3);
    ck("cache drop", ci_q, 1);
    ck("self test", bs_q, 1);
    ck("config", cfg, 5'h00);
    finish_test();
  end
endmodule : cpu_bus_sideband_control_tb
